// ==== logic/sfc_device.sv ====
// Drive end: spin-up sequencing, format and mode-select handling
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sfc_map.svh"
module sfc_device import sfc_pkg::*; #(
   parameter int TW = 40,
   parameter logic [39:0] INIT_CYC = `SFC_INIT_CYC,
   parameter logic [39:0] SPIN_CYC = `SFC_SPIN_CYC,
   parameter logic [39:0] STOP_CYC = `SFC_STOP_CYC,
   parameter logic [39:0] NTF_CYC = `SFC_NTF_CYC,
   parameter logic [39:0] FAST_CYC = `SFC_FAST_CYC,
   parameter logic [39:0] FULL_CYC = `SFC_FULL_CYC,
   parameter logic [39:0] EXTRA_CYC = `SFC_EXTRA_CYC,
   parameter bit NATIVE_512_ONLY = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Link to the initiator
   sfc_if.dev lnk,
   // Drive-side status
   output logic dev_ready,
   output logic fmt_busy,
   output logic [15:0] block_len,
   output logic prefetch_en,
   output logic read_cache_en
);
   sfc_spin_t spin_reg, spin_next;
   sfc_cmd_t cmd_reg, cmd_next;
   logic [15:0] cur_len_reg, cur_len_next;
   logic [15:0] pend_len_reg, pend_len_next;
   logic dra_reg, dra_next;
   logic rcd_reg, rcd_next;
   logic [39:0] fmt_lim_reg, fmt_lim_next;
   logic fmt_immediate_flag_reg, fmt_immediate_flag_next;
   logic sv_reg, sv_next;
   // Sense image {check, key, asc, pointer byte, pointer bit}
   logic [23:0] sns_reg, sns_next;
   logic ntf;
   logic take;
   logic hit_init, hit_spin, hit_ntf, hit_fmt;
   logic [39:0] spin_lim;
   logic [18:0] cur8, pend8;
   logic conv_ok;
   logic size_ok;
   logic media_op;

   assign ntf = lnk.notify_a || lnk.notify_b;
   // Commands held off until power-on init is done
   assign lnk.cmd_ready = (spin_reg != SP_INIT) && (cmd_reg == CM_IDLE) && !lnk.power_disable;
   assign take = lnk.cmd_valid && lnk.cmd_ready;
   assign spin_lim = (spin_reg == SP_STOPPING) ? STOP_CYC : SPIN_CYC;
   assign cur8 = {cur_len_reg, 3'h0};
   assign pend8 = {pend_len_reg, 3'h0};
   // Exact multiple of 8 either way, or unchanged
   assign conv_ok = (cur_len_reg == pend_len_reg) || (cur8 == 19'(pend_len_reg)) ||
                    (pend8 == 19'(cur_len_reg));
   // Supported logical block lengths
   assign size_ok = (lnk.prm_block_len == `SFC_LEN_512) || (lnk.prm_block_len == `SFC_LEN_520) ||
                    (lnk.prm_block_len == `SFC_LEN_528) ||
                    (!NATIVE_512_ONLY && ((lnk.prm_block_len == `SFC_LEN_4096) ||
                    (lnk.prm_block_len == `SFC_LEN_4160) || (lnk.prm_block_len == `SFC_LEN_4224)));
   assign media_op = (lnk.cdb_op == `SFC_OP_TUR) || (lnk.cdb_op == `SFC_OP_READ6) ||
                     (lnk.cdb_op == `SFC_OP_WRITE6) || (lnk.cdb_op == `SFC_OP_READ10) ||
                     (lnk.cdb_op == `SFC_OP_WRITE10);

   sfc_timer #(.TW(TW)) u_init (
      .clk(clk), .arst_n(arst_n), .run(spin_reg == SP_INIT), .limit(TW'(INIT_CYC)),
      .hit(hit_init)
   );
   sfc_timer #(.TW(TW)) u_spin (
      .clk(clk), .arst_n(arst_n),
      .run((spin_reg == SP_SPINUP) || (spin_reg == SP_STOPPING)),
      .limit(TW'(spin_lim)), .hit(hit_spin)
   );
   sfc_timer #(.TW(TW)) u_ntf (
      .clk(clk), .arst_n(arst_n), .run(cmd_reg == CM_START_WAIT), .limit(TW'(NTF_CYC)),
      .hit(hit_ntf)
   );
   sfc_timer #(.TW(TW)) u_fmt (
      .clk(clk), .arst_n(arst_n), .run(cmd_reg == CM_FORMAT), .limit(TW'(fmt_lim_reg)),
      .hit(hit_fmt)
   );

   always_comb begin
      spin_next = spin_reg;
      cmd_next = cmd_reg;
      cur_len_next = cur_len_reg;
      pend_len_next = pend_len_reg;
      dra_next = dra_reg;
      rcd_next = rcd_reg;
      fmt_lim_next = fmt_lim_reg;
      fmt_immediate_flag_next = fmt_immediate_flag_reg;
      sv_next = 1'b0;
      sns_next = sns_reg;
      // Spindle sequencing
      case (spin_reg)
         SP_INIT: if (hit_init) spin_next = SP_WAIT_NTF;
         SP_WAIT_NTF, SP_WAIT_NTF2: if (ntf) spin_next = SP_SPINUP;
         SP_SPINUP: if (hit_spin) spin_next = SP_READY;
         SP_STOPPING: if (hit_spin) spin_next = SP_STOPPED;
         default: ;
      endcase
      // Completion of long-running commands
      case (cmd_reg)
         CM_START_WAIT: begin
            if (ntf) begin
               cmd_next = CM_IDLE;
               sv_next = 1'b1;
               sns_next = '0;
            end else if (hit_ntf) begin
               // No notify in the window: the start fails
               cmd_next = CM_IDLE;
               sv_next = 1'b1;
               sns_next = {1'b1, `SFC_KEY_NOT_READY, `SFC_ASC_NOT_READY, 11'h000};
            end
         end
         CM_STOP_WAIT: begin
            if (spin_reg == SP_STOPPED) begin
               cmd_next = CM_IDLE;
               sv_next = 1'b1;
               sns_next = '0;
            end
         end
         CM_FORMAT: begin
            if (hit_fmt) begin
               cmd_next = CM_IDLE;
               cur_len_next = pend_len_reg;
               sv_next = !fmt_immediate_flag_reg;
               sns_next = '0;
            end
         end
         default: ;
      endcase
      // New command, decoded in the cycle it is taken
      if (take) begin
         sv_next = 1'b1;
         sns_next = '0;
         case (lnk.cdb_op)
            `SFC_OP_FORMAT: begin
               if (lnk.cdb_b4[1]) begin
                  // Reserved fast-format values
                  sns_next = {1'b1, `SFC_KEY_ILLEGAL, `SFC_ASC_BAD_CDB, `SFC_FP_BYTE,
                              `SFC_FP_BIT};
               end else if (spin_reg != SP_READY) begin
                  sns_next = {1'b1, `SFC_KEY_NOT_READY, `SFC_ASC_NOT_READY, 11'h000};
               end else if ((lnk.cdb_b4[1:0] == `SFC_FAST_FORMAT_FIELD_FAST) && !conv_ok) begin
                  sns_next = {1'b1, `SFC_KEY_ILLEGAL, `SFC_ASC_BAD_PRM, 11'h000};
               end else begin
                  cmd_next = CM_FORMAT;
                  fmt_immediate_flag_next = lnk.prm_fmt_hdr[`SFC_FMT_IMMEDIATE_FLAG_BIT];
                  sv_next = lnk.prm_fmt_hdr[`SFC_FMT_IMMEDIATE_FLAG_BIT];
                  if (lnk.cdb_b4[1:0] == `SFC_FAST_FORMAT_FIELD_FAST) begin
                     fmt_lim_next = FAST_CYC;
                  end else if (cur_len_reg != pend_len_reg) begin
                     fmt_lim_next = 40'(FULL_CYC + EXTRA_CYC);
                  end else begin
                     fmt_lim_next = FULL_CYC;
                  end
               end
            end
            `SFC_OP_MSEL10: begin
               if (lnk.prm_page == `SFC_PAGE_CACHE) begin
                  // Each bit stands on its own
                  dra_next = lnk.prm_pg_b12[`SFC_DRA_BIT];
                  rcd_next = lnk.prm_pg_b2[`SFC_RCD_BIT];
               end else if ((lnk.prm_desc_len == `SFC_DESC_LEN) && size_ok &&
                            (lnk.prm_block_count == `SFC_ALL_ONES)) begin
                  pend_len_next = lnk.prm_block_len;
               end else begin
                  sns_next = {1'b1, `SFC_KEY_ILLEGAL, `SFC_ASC_BAD_PRM, 11'h000};
               end
            end
            `SFC_OP_SSU: begin
               if (!lnk.cdb_b4[0]) begin
                  if (spin_reg == SP_WAIT_NTF) begin
                     spin_next = SP_WAIT_START;
                  end else if ((spin_reg == SP_READY) || (spin_reg == SP_SPINUP)) begin
                     spin_next = SP_STOPPING;
                     if (!lnk.cdb_b1[0]) begin
                        cmd_next = CM_STOP_WAIT;
                        sv_next = 1'b0;
                     end
                  end
               end else begin
                  if (spin_reg == SP_WAIT_START) begin
                     spin_next = SP_WAIT_NTF2;
                  end else if (spin_reg == SP_STOPPED) begin
                     spin_next = SP_SPINUP;
                  end
                  if (lnk.cdb_b1[0] && ((spin_reg == SP_WAIT_START) ||
                      (spin_reg == SP_WAIT_NTF) || (spin_reg == SP_WAIT_NTF2))) begin
                     cmd_next = CM_START_WAIT;
                     sv_next = 1'b0;
                  end
               end
            end
            default: begin
               if (media_op && (spin_reg != SP_READY)) begin
                  sns_next = {1'b1, `SFC_KEY_NOT_READY, `SFC_ASC_NOT_READY, 11'h000};
               end
            end
         endcase
      end
      // Power-disable restarts sequencing; saved pages survive
      if (lnk.power_disable) begin
         spin_next = SP_INIT;
         cmd_next = CM_IDLE;
         sv_next = 1'b0;
      end
      // Sense stands until the next status
      if (!sv_next) sns_next = sns_reg;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         spin_reg <= SP_INIT;
         cmd_reg <= CM_IDLE;
         cur_len_reg <= `SFC_LEN_512;
         pend_len_reg <= `SFC_LEN_512;
         dra_reg <= 1'b0;
         rcd_reg <= 1'b0;
         fmt_lim_reg <= 40'h1;
         fmt_immediate_flag_reg <= 1'b0;
         sv_reg <= 1'b0;
         sns_reg <= 24'h000000;
      end else begin
         spin_reg <= spin_next;
         cmd_reg <= cmd_next;
         cur_len_reg <= cur_len_next;
         pend_len_reg <= pend_len_next;
         dra_reg <= dra_next;
         rcd_reg <= rcd_next;
         fmt_lim_reg <= fmt_lim_next;
         fmt_immediate_flag_reg <= fmt_immediate_flag_next;
         sv_reg <= sv_next;
         sns_reg <= sns_next;
      end
   end

   assign lnk.sts_valid = sv_reg;
   assign lnk.sts_check = sns_reg[23];
   assign lnk.sense_key = sns_reg[22:19];
   assign lnk.sense_asc = sns_reg[18:11];
   assign lnk.sense_fp_byte = sns_reg[10:3];
   assign lnk.sense_fp_bit = sns_reg[2:0];
   assign dev_ready = (spin_reg == SP_READY);
   assign fmt_busy = (cmd_reg == CM_FORMAT);
   assign block_len = cur_len_reg;
   assign prefetch_en = !dra_reg;
   assign read_cache_en = !rcd_reg;
endmodule

// ==== logic/sfc_host.sv ====
// Initiator end: APB-programmed command issue over the link
`timescale 1ns/1ps
`include "sfc_map.svh"
module sfc_host import sfc_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link to the drive
   sfc_if.host lnk
);
   sfc_host_t st_reg, st_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] cmd_reg, cmd_next;
   logic [31:0] blk_reg, blk_next;
   logic [31:0] cnt_reg, cnt_next;
   logic [31:0] page_reg, page_next;
   logic [31:0] fmt_reg, fmt_next;
   logic [31:0] stat_reg, stat_next;
   logic wr, send;
   sfc_kind_t kind;

   assign wr = psel && penable && pwrite;
   assign send = wr && (paddr == `SFC_REG_CTRL) && pwdata[`SFC_CTRL_SEND] && (st_reg == H_IDLE);
   assign kind = sfc_kind_t'(pwdata[6:4]);
   assign pready = 1'b1;
   assign pslverr = psel && penable && (paddr > `SFC_REG_STAT || paddr[1:0] != 2'h0);

   always_comb begin
      case (paddr)
         `SFC_REG_CTRL: prdata = ctrl_reg;
         `SFC_REG_CMD: prdata = cmd_reg;
         `SFC_REG_BLK: prdata = blk_reg;
         `SFC_REG_CNT: prdata = cnt_reg;
         `SFC_REG_PAGE: prdata = page_reg;
         `SFC_REG_FMT: prdata = fmt_reg;
         `SFC_REG_STAT: prdata = stat_reg;
         default: prdata = 32'h00000000;
      endcase
   end

   always_comb begin
      st_next = st_reg;
      ctrl_next = {ctrl_reg[31:4], 2'h0, ctrl_reg[1:0]} & 32'h00000002;
      cmd_next = cmd_reg;
      blk_next = blk_reg;
      cnt_next = cnt_reg;
      page_next = page_reg;
      fmt_next = fmt_reg;
      stat_next = stat_reg;
      if (wr) begin
         case (paddr)
            // Power cycle by raising then dropping power-disable
            `SFC_REG_CTRL: ctrl_next = pwdata & 32'h0000000E;
            `SFC_REG_CMD: cmd_next = pwdata;
            `SFC_REG_BLK: blk_next = pwdata;
            `SFC_REG_CNT: cnt_next = pwdata;
            `SFC_REG_PAGE: page_next = pwdata;
            `SFC_REG_FMT: fmt_next = pwdata;
            `SFC_REG_STAT: if (pwdata[`SFC_STAT_DONE]) stat_next[`SFC_STAT_DONE] = 1'b0;
            default: ;
         endcase
      end
      // A preset rewrites the working registers in the send cycle
      if (send) begin
         st_next = H_SEND;
         stat_next[0] = 1'b1;
         case (kind)
            K_SIZE512, K_SIZE4096: begin
               // Sector-size select list and command
               cmd_next = {`SFC_MS_PLEN, 8'h00, `SFC_MS_B1, `SFC_OP_MSEL10};
               blk_next = {8'h00, `SFC_DESC_LEN,
                           kind == K_SIZE512 ? `SFC_LEN_512 : `SFC_LEN_4096};
               cnt_next = `SFC_ALL_ONES;
               page_next = 32'h00000000;
            end
            K_FASTFMT: begin
               // Fast format with immediate header
               cmd_next = {8'h00, 6'h00, `SFC_FAST_FORMAT_FIELD_FAST, `SFC_FMT_B1, `SFC_OP_FORMAT};
               fmt_next = `SFC_FMT_HDR;
            end
            K_START: cmd_next = {8'h00, 8'h01, 8'h01, `SFC_OP_SSU};
            K_STOP: cmd_next = {8'h00, 8'h00, 8'h00, `SFC_OP_SSU};
            default: ;
         endcase
      end
      case (st_reg)
         H_SEND: if (lnk.cmd_ready) st_next = H_WAIT;
         H_WAIT: begin
            if (lnk.sts_valid) begin
               st_next = H_IDLE;
               stat_next = {lnk.sense_fp_byte, lnk.sense_asc, 4'h0, lnk.sense_key,
                            1'b0, lnk.sense_fp_bit, 1'b0, lnk.sts_check, 1'b1, 1'b0};
            end
         end
         default: ;
      endcase
      // Power-disable abandons any command in flight
      if (ctrl_reg[`SFC_CTRL_PDIS]) begin
         st_next = H_IDLE;
         stat_next[0] = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= H_IDLE;
         ctrl_reg <= 32'h00000000;
         cmd_reg <= 32'h00000000;
         blk_reg <= 32'h00000000;
         cnt_reg <= 32'h00000000;
         page_reg <= 32'h00000000;
         fmt_reg <= 32'h00000000;
         stat_reg <= 32'h00000000;
      end else begin
         st_reg <= st_next;
         ctrl_reg <= ctrl_next;
         cmd_reg <= cmd_next;
         blk_reg <= blk_next;
         cnt_reg <= cnt_next;
         page_reg <= page_next;
         fmt_reg <= fmt_next;
         stat_reg <= stat_next;
      end
   end

   // Fields are driven from the working registers; APB writes to them still land in H_SEND
   assign lnk.cmd_valid = (st_reg == H_SEND);
   assign lnk.cdb_op = cmd_reg[7:0];
   assign lnk.cdb_b1 = cmd_reg[15:8];
   assign lnk.cdb_b4 = cmd_reg[23:16];
   assign lnk.cdb_plen = cmd_reg[31:24];
   assign lnk.prm_block_len = blk_reg[15:0];
   assign lnk.prm_desc_len = blk_reg[23:16];
   assign lnk.prm_block_count = cnt_reg;
   assign lnk.prm_page = page_reg[7:0];
   assign lnk.prm_pg_b2 = page_reg[15:8];
   assign lnk.prm_pg_b12 = page_reg[23:16];
   assign lnk.prm_fmt_hdr = fmt_reg;
   assign lnk.notify_a = ctrl_reg[`SFC_CTRL_NTFA];
   assign lnk.notify_b = ctrl_reg[`SFC_CTRL_NTFB];
   assign lnk.power_disable = ctrl_reg[`SFC_CTRL_PDIS];
endmodule

// ==== logic/sfc_if.sv ====
// Command link between the initiator end and the drive end
`timescale 1ns/1ps
interface sfc_if;
   logic cmd_valid;
   logic cmd_ready;
   logic [7:0] cdb_op;
   logic [7:0] cdb_b1;
   logic [7:0] cdb_b4;
   logic [7:0] cdb_plen;
   logic [7:0] prm_desc_len;
   logic [31:0] prm_block_count;
   logic [15:0] prm_block_len;
   logic [7:0] prm_page;
   logic [7:0] prm_pg_b2;
   logic [7:0] prm_pg_b12;
   logic [31:0] prm_fmt_hdr;
   logic sts_valid;
   logic sts_check;
   logic [3:0] sense_key;
   logic [7:0] sense_asc;
   logic [7:0] sense_fp_byte;
   logic [2:0] sense_fp_bit;
   logic notify_a;
   logic notify_b;
   logic power_disable;
   modport dev (
      input cmd_valid, cdb_op, cdb_b1, cdb_b4, cdb_plen, prm_desc_len, prm_block_count,
      input prm_block_len, prm_page, prm_pg_b2, prm_pg_b12, prm_fmt_hdr,
      input notify_a, notify_b, power_disable,
      output cmd_ready, sts_valid, sts_check, sense_key, sense_asc, sense_fp_byte,
      output sense_fp_bit
   );
   modport host (
      output cmd_valid, cdb_op, cdb_b1, cdb_b4, cdb_plen, prm_desc_len, prm_block_count,
      output prm_block_len, prm_page, prm_pg_b2, prm_pg_b12, prm_fmt_hdr,
      output notify_a, notify_b, power_disable,
      input cmd_ready, sts_valid, sts_check, sense_key, sense_asc, sense_fp_byte,
      input sense_fp_bit
   );
endinterface

// ==== logic/sfc_map.svh ====
// Constants for the spin-up and format control ends
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
`define SFC_CLK_HZ 20000000
`define SFC_INIT_S 3
`define SFC_SPIN_S 20
`define SFC_STOP_S 20
`define SFC_NTF_S 5
`define SFC_FAST_S 1
`define SFC_FMT_MIN 420
`define SFC_FMT_EXTRA_MIN 30
`define SFC_INIT_CYC (40'(`SFC_INIT_S) * 40'(`SFC_CLK_HZ))
`define SFC_SPIN_CYC (40'(`SFC_SPIN_S) * 40'(`SFC_CLK_HZ))
`define SFC_STOP_CYC (40'(`SFC_STOP_S) * 40'(`SFC_CLK_HZ))
`define SFC_NTF_CYC (40'(`SFC_NTF_S) * 40'(`SFC_CLK_HZ))
`define SFC_FAST_CYC (40'(`SFC_FAST_S) * 40'(`SFC_CLK_HZ))
`define SFC_FULL_CYC (40'(`SFC_FMT_MIN) * 40'(60) * 40'(`SFC_CLK_HZ))
`define SFC_EXTRA_CYC (40'(`SFC_FMT_EXTRA_MIN) * 40'(60) * 40'(`SFC_CLK_HZ))
`define SFC_OP_TUR 8'h00
`define SFC_OP_FORMAT 8'h04
`define SFC_OP_READ6 8'h08
`define SFC_OP_WRITE6 8'h0A
`define SFC_OP_SSU 8'h1B
`define SFC_OP_READ10 8'h28
`define SFC_OP_WRITE10 8'h2A
`define SFC_OP_MSEL10 8'h55
`define SFC_FAST_FORMAT_FIELD_FAST 2'h1
`define SFC_FMT_B1 8'h14
`define SFC_FMT_HDR 32'h00020000
`define SFC_FMT_IMMEDIATE_FLAG_BIT 17
`define SFC_MS_B1 8'h01
`define SFC_MS_PLEN 8'h10
`define SFC_DESC_LEN 8'h08
`define SFC_ALL_ONES 32'hFFFFFFFF
`define SFC_LEN_512 16'h0200
`define SFC_LEN_520 16'h0208
`define SFC_LEN_528 16'h0210
`define SFC_LEN_4096 16'h1000
`define SFC_LEN_4160 16'h1040
`define SFC_LEN_4224 16'h1080
`define SFC_PAGE_CACHE 8'h08
`define SFC_DRA_BIT 5
`define SFC_RCD_BIT 0
`define SFC_KEY_NOT_READY 4'h2
`define SFC_KEY_ILLEGAL 4'h5
`define SFC_ASC_NOT_READY 8'h04
`define SFC_ASC_BAD_CDB 8'h24
`define SFC_ASC_BAD_PRM 8'h26
`define SFC_FP_BYTE 8'h04
`define SFC_FP_BIT 3'h1
`define SFC_REG_CTRL 8'h00
`define SFC_REG_CMD 8'h04
`define SFC_REG_BLK 8'h08
`define SFC_REG_CNT 8'h0C
`define SFC_REG_PAGE 8'h10
`define SFC_REG_FMT 8'h14
`define SFC_REG_STAT 8'h18
`define SFC_CTRL_SEND 0
`define SFC_CTRL_PDIS 1
`define SFC_CTRL_NTFA 2
`define SFC_CTRL_NTFB 3
`define SFC_STAT_DONE 1
`endif

// ==== logic/sfc_pkg.sv ====
// Types shared by the spin-up and format control ends
package sfc_pkg;
   typedef enum logic [2:0] {
      SP_INIT, SP_WAIT_NTF, SP_WAIT_START, SP_WAIT_NTF2,
      SP_SPINUP, SP_READY, SP_STOPPING, SP_STOPPED
   } sfc_spin_t;
   typedef enum logic [1:0] {CM_IDLE, CM_START_WAIT, CM_STOP_WAIT, CM_FORMAT} sfc_cmd_t;
   typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} sfc_host_t;
   typedef enum logic [2:0] {
      K_RAW, K_SIZE512, K_SIZE4096, K_FASTFMT, K_START, K_STOP
   } sfc_kind_t;
endpackage

// ==== logic/sfc_timer.sv ====
// Elapsed-time counter: hit is high from the limit-th cycle of run for as long as run stays high
`timescale 1ns/1ps
module sfc_timer #(
   parameter int TW = 40
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Control
   input wire logic run,
   input wire logic [TW-1:0] limit,
   output logic hit
);
   logic [TW-1:0] cnt_reg;
   logic [TW-1:0] cnt_next;

   // Limit of zero is treated as one cycle
   assign hit = run && (cnt_reg + TW'(1) >= limit);

   always_comb begin
      cnt_next = run ? cnt_reg + TW'(1) : '0;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule

// ==== verif/sfc_link_monitor.sv ====
// Link checker for the spin-up and format control ends
`timescale 1ns/1ps
module sfc_link_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Link
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [7:0] cdb_op,
   input wire logic [7:0] cdb_b4,
   input wire logic [7:0] prm_desc_len,
   input wire logic [31:0] prm_block_count,
   input wire logic [15:0] prm_block_len,
   input wire logic [7:0] prm_page,
   input wire logic sts_valid,
   input wire logic sts_check,
   input wire logic [3:0] sense_key,
   input wire logic [7:0] sense_asc,
   input wire logic [7:0] sense_fp_byte,
   input wire logic [2:0] sense_fp_bit,
   input wire logic power_disable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic ms;
   logic len_ok;
   assign ms = cmd_valid && cmd_ready && cdb_op == 8'h55;
   assign len_ok = prm_block_len inside {16'h0200, 16'h0208, 16'h0210, 16'h1000, 16'h1040,
      16'h1080};
   init_hold_a: assert property ($rose(arst_n) |-> !cmd_ready [*8])
      else $error("link ready too early after reset");
   pdis_block_a: assert property (power_disable |-> !cmd_ready)
      else $error("command taken while power disabled");
   fast_format_field_bad_a: assert property (cmd_valid && cmd_ready && cdb_op == 8'h04 && cdb_b4[1]
      |=> sts_valid && sts_check && sense_key == 4'h5 && sense_asc == 8'h24
      && sense_fp_byte == 8'h04 && sense_fp_bit == 3'h1) else $error("bad fast format code");
   sts_pulse_a: assert property (sts_valid |=> !sts_valid)
      else $error("status longer than one cycle");
   sense_hold_a: assert property (!sts_valid |-> $stable({sts_check, sense_key, sense_asc}))
      else $error("sense changed without status");
   page_ok_a: assert property (ms && prm_page == 8'h08 |=> sts_valid && !sts_check)
      else $error("cache page refused");
   size_ok_a: assert property (ms && prm_page != 8'h08 && prm_desc_len == 8'h08
      && prm_block_count == 32'hFFFFFFFF && len_ok |=> sts_valid && !sts_check)
      else $error("supported size refused");
   size_bad_a: assert property (ms && prm_page != 8'h08 && !len_ok
      |=> sts_valid && sense_key == 4'h5 && sense_asc == 8'h26) else $error("bad size taken");
endmodule

// ==== verif/test_spinup_and_fast_format_control.sv ====
// Self-checking bench for the spin-up and format control ends
`timescale 1ns/1ps
module test_spinup_and_fast_format_control;
   logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, st;
   logic pready, pslverr, dev_ready, fmt_busy, prefetch_en, read_cache_en;
   logic [15:0] block_len;
   int errors = 0, n_checks = 0, exp_len = 512;
   sfc_if lnk ();
   sfc_host i_sfc_host (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lnk(lnk));
   sfc_device #(.INIT_CYC(40'd40), .SPIN_CYC(40'd100), .STOP_CYC(40'd60), .NTF_CYC(40'd60),
      .FAST_CYC(40'd80), .FULL_CYC(40'd150), .EXTRA_CYC(40'd30)) i_sfc_device (.clk(clk),
      .arst_n(arst_n), .lnk(lnk),
      .dev_ready(dev_ready), .fmt_busy(fmt_busy), .block_len(block_len),
      .prefetch_en(prefetch_en), .read_cache_en(read_cache_en));
   sfc_link_monitor i_mon (.clk(clk), .arst_n(arst_n), .cmd_valid(lnk.cmd_valid),
      .cmd_ready(lnk.cmd_ready), .cdb_op(lnk.cdb_op), .cdb_b4(lnk.cdb_b4),
      .prm_desc_len(lnk.prm_desc_len), .prm_block_count(lnk.prm_block_count),
      .prm_block_len(lnk.prm_block_len), .prm_page(lnk.prm_page), .sts_valid(lnk.sts_valid),
      .sts_check(lnk.sts_check), .sense_key(lnk.sense_key), .sense_asc(lnk.sense_asc),
      .sense_fp_byte(lnk.sense_fp_byte), .sense_fp_bit(lnk.sense_fp_bit),
      .power_disable(lnk.power_disable));
   initial forever #25 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1;
      @(posedge clk);
      for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge clk);
      if (n == 20) begin
         chk(0, 1);
         close_out();
      end
      if (!w) st = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   // Expected status packs {check, key, asc}
   task automatic send(input int kind, input logic [31:0] extra, input logic [12:0] exp);
      int n;
      apb(1, 8'h00, 32'(kind << 4) | 32'h1);
      if (extra != 0) apb(1, 8'h00, extra);
      for (n = 0; n < 400; n++) begin
         apb(0, 8'h18, 32'h0);
         if (st[1] === 1'b1) break;
      end
      if (n == 400) begin
         chk(0, 1);
         close_out();
      end
      chk(32'({st[2], st[11:8], st[23:16]}), 32'(exp));
      apb(1, 8'h18, 32'h2);
   endtask
   task automatic raw(input logic [31:0] cmd, blk, pg, input logic [12:0] exp);
      apb(1, 8'h04, cmd);
      apb(1, 8'h08, blk);
      apb(1, 8'h0C, 32'hFFFFFFFF);
      apb(1, 8'h10, pg);
      send(0, 0, exp);
   endtask
   task automatic wait_for(input int n, ref logic s, input logic v);
      for (int i = 0; i < n && s !== v; i++) @(posedge clk);
      chk(32'(s), 32'(v));
      if (s !== v) close_out();
   endtask
   task automatic close_out();
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      void'($urandom(8));
      repeat (16) @(posedge clk);
      arst_n <= 1;
      @(posedge clk);
      raw(32'h00000028, 0, 0, 13'h1204);
      for (int k = 2; k < 4; k++) begin
         raw(32'h00001404 | 32'(k << 16), 0, 0, 13'h1524);
         chk(32'({st[31:24], st[6:4]}), 32'({8'h04, 3'h1}));
      end
      send(2, 0, 0);
      chk(32'(block_len), 32'(exp_len));
      send(5, 0, 0);
      send(4, 0, 13'h1204);
      send(4, 32'h8, 0);
      wait_for(120, dev_ready, 1);
      repeat (4) begin
         logic [7:0] b2, b12;
         b2 = 8'($urandom);
         b12 = 8'($urandom);
         raw(32'h10000155, 0, {8'h0, b12, b2, 8'h08}, 0);
         chk(32'({prefetch_en, read_cache_en}), 32'({~b12[5], ~b2[0]}));
      end
      exp_len = 4096;
      send(3, 0, 0);
      wait_for(100, fmt_busy, 0);
      chk(32'(block_len), 32'(exp_len));
      raw(32'h10000155, 32'h00081040, 0, 0);
      send(3, 0, 13'h1526);
      raw(32'h10000155, 32'h00080300, 0, 13'h1526);
      send(1, 0, 0);
      exp_len = 512;
      send(3, 0, 0);
      wait_for(100, fmt_busy, 0);
      chk(32'(block_len), 32'(exp_len));
      send(2, 0, 0);
      raw(32'h00001004, 0, 0, 0);
      repeat (160) @(posedge clk);
      chk(32'(fmt_busy), 1);
      wait_for(40, fmt_busy, 0);
      exp_len = 4096;
      chk(32'(block_len), 32'(exp_len));
      send(5, 0, 0);
      wait_for(80, dev_ready, 0);
      send(4, 0, 0);
      wait_for(120, dev_ready, 1);
      apb(1, 8'h00, 32'h2);
      chk(32'(lnk.cmd_ready), 0);
      apb(1, 8'h00, 32'h0);
      close_out();
   end
   initial begin
      repeat (100000) @(posedge clk);
      chk(0, 1);
      close_out();
   end
endmodule
